//--- interrupt_and_supply_monitor_ctrl.sv
// interrupt request/enable registers and supply detector control
// assumes a synchronous register port and an asynchronous comparator
//
// Functional notes
// [R1] three-bit trip level select, 000 lowest 2.0V up to 111 at 4.0V
// [R2] read-only bit 5 shows supply below selected trip level
// [R3] bit 4 switches the supply detector on or off
// [R4] sleep mode switches the detector off regardless of its enable
// [R5] software waits for stabilisation before trusting the low flag
// [R6] supply-low request raised only after fixed delay from flag rise
// [R7] idle with detector on: keep running, set flag, wake on low
// [R8] software presets supply-low request flag to avoid idle wake-up
// [R9] bit 3 enables bandgap reference output
// [R10] bits 7 and 6 of supply monitor register read zero
// [R11] every source has its own enable bit and request flag
// [R12] grouped sources form multi-function groups 0..5 with own bits
// [R13] supply-low flag bit 4, enable bit 0 of multi register 3
// [R14] two-bit edge select: off, rising, falling, both
// [R15] edge selects packed pin 3 high to pin 0 low, cleared at reset
// [R16] flags: 1 pending, cleared at power-up, writable by software
// [R17] primary reg 0: flags at 6,5,4, comparator enable 3, bit 7 zero
// [R18] enable bit 0 blocks its source, 1 allows it
// [R19] global enable at bit 0 of primary reg 0 gates every request; WAKE_OUT is not gated by it
// [R20] group flag set while any member has flag and enable set
`timescale 1ns/10ps
`default_nettype none

`include "irq_supply_cfg.svh"

module interrupt_and_supply_monitor_ctrl #(
  parameter int unsigned NUM_PINS           = 4,
  parameter int unsigned RAISE_DELAY_CYCLES = `IRQ_RAISE_DELAY_CYCLES
) (
  // clock and reset
  input  wire logic                            CLK_SYS_IN,
  input  wire logic                            RESET_IN,
  // special function register port
  input  wire logic [7:0]                      SFR_ADDR_IN,
  input  wire logic                            SFR_WR_IN,
  input  wire irq_supply_pkg::sfr_byte_t       SFR_WDATA_IN,
  output irq_supply_pkg::sfr_byte_t            SFR_RDATA_OUT,
  // power modes from the core
  input  wire logic                            SLEEP_MODE_IN,
  input  wire logic                            IDLE_MODE_IN,
  // analogue detector side
  input  wire logic                            SUPPLY_BELOW_TRIP_IN,
  output logic                                 DETECTOR_ON_OUT,
  output irq_supply_pkg::trip_level_t          TRIP_LEVEL_OUT,
  output logic                                 BANDGAP_OUT_ENABLE_OUT,
  // interrupt sources
  input  wire logic [NUM_PINS-1:0]             EXTERNAL_IRQ_PINS_IN,
  input  wire logic [`NUM_PRIMARY_SRC-1:0]     PRIMARY_EVENT_IN,
  input  wire logic [4*`NUM_MULTI_REGS-1:0]    MEMBER_EVENT_IN,
  // requests to the core
  output logic                                 IRQ_REQ_OUT,
  output logic                                 WAKE_OUT
);
  import irq_supply_pkg::*;

  generate
    if (NUM_PINS != 4) begin : g_bad_pins
      $error("edge select register serves exactly four pins");
    end
  endgenerate

  // ****************************************************************
  // helpers
  // ****************************************************************
  // any flag in bits 7:4 paired with its enable in bits 3:0
  function automatic logic pair_pending(input sfr_byte_t r);
    pair_pending = |(r[7:4] & r[3:0]);
  endfunction

  // software write or hold, then hardware set wins
  function automatic sfr_byte_t next_reg(input sfr_byte_t cur,
                                         input sfr_byte_t ev,
                                         input logic      hit,
                                         input sfr_byte_t wdata,
                                         input sfr_byte_t mask);
    next_reg = ((hit ? wdata : cur) | ev) & mask;
  endfunction

  function automatic logic is_addr(input logic [7:0] a,
                                   input logic [7:0] off);
    is_addr = SFR_WR_IN && (a == off);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  sfr_byte_t              supply_mon_r;
  sfr_byte_t              edge_sel_r;
  sfr_byte_t              primary_r [`NUM_PRIMARY_REGS];
  sfr_byte_t              multi_r   [`NUM_MULTI_REGS];
  sfr_byte_t              primary_ev [`NUM_PRIMARY_REGS];
  sfr_byte_t              multi_ev   [`NUM_MULTI_REGS];
  sfr_byte_t              rdata_nxt;
  logic                   below_meta_r;
  logic                   below_sync_r;
  logic                   detector_active;
  logic                   supply_low_flag;
  logic                   supply_irq_fire;
  logic [NUM_PINS-1:0]    pin_edge;
  logic [`NUM_MULTI_REGS-1:0] group_active;
  logic                   primary_pend;
  logic                   wake_r;

  // ****************************************************************
  // supply monitor register
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      supply_mon_r <= `REG_RESET;
    end else if (is_addr(SFR_ADDR_IN, `SFR_SUPPLY_MON)) begin
      supply_mon_r <= SFR_WDATA_IN & `SM_WRITE_MASK;  // [R1] [R9]
    end
  end

  assign TRIP_LEVEL_OUT         = supply_mon_r[`SM_LEVEL_MSB:0];  // [R1]
  assign BANDGAP_OUT_ENABLE_OUT = supply_mon_r[`SM_BANDGAP_BIT];  // [R9]

  // ****************************************************************
  // detector control and low flag
  // ****************************************************************
  // sleep turns the detector off, idle keeps it running
  assign detector_active = supply_mon_r[`SM_ON_BIT]
                         & ~SLEEP_MODE_IN;  // [R3] [R4] [R7]
  assign DETECTOR_ON_OUT = detector_active;

  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      below_meta_r <= 1'b0;
      below_sync_r <= 1'b0;
    end else begin
      below_meta_r <= SUPPLY_BELOW_TRIP_IN;
      below_sync_r <= below_meta_r;
    end
  end

  // an unpowered detector reports no low supply
  assign supply_low_flag = below_sync_r & detector_active;  // [R2]

  supply_irq_delay #(
    .CYCLES (RAISE_DELAY_CYCLES)
  ) u_delay (
    .clk_in   (CLK_SYS_IN),
    .rst_in   (RESET_IN),
    .level_in (supply_low_flag),
    .fire_out (supply_irq_fire)
  );

  // ****************************************************************
  // external pin edge select
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      edge_sel_r <= `REG_RESET;  // [R15]
    end else if (is_addr(SFR_ADDR_IN, `SFR_EDGE_SEL)) begin
      edge_sel_r <= SFR_WDATA_IN;  // [R15]
    end
  end

  pin_edge_detect #(
    .NUM_PINS (NUM_PINS)
  ) u_edges (
    .clk_in   (CLK_SYS_IN),
    .rst_in   (RESET_IN),
    .pins_in  (EXTERNAL_IRQ_PINS_IN),
    .sel_in   (edge_sel_r),
    .edge_out (pin_edge)
  );

  // ****************************************************************
  // hardware events onto flag positions
  // ****************************************************************
  always_comb begin
    for (int g = 0; g < `NUM_MULTI_REGS; g++) begin
      group_active[g] = pair_pending(multi_r[g]);  // [R20]
      multi_ev[g]     = {MEMBER_EVENT_IN[4*g +: 4], 4'h0};  // [R11]
    end
    multi_ev[`SUPPLY_GROUP][`SUPPLY_IRQ_FLAG] =
      MEMBER_EVENT_IN[4*`SUPPLY_GROUP] | supply_irq_fire;  // [R13] [R7]
  end

  // group flags sit in the primary registers
  always_comb begin
    primary_ev[0] = {1'b0, PRIMARY_EVENT_IN[`SRC_CP0],
                     pin_edge[1], pin_edge[0], 4'h0};  // [R17]
    primary_ev[1] = {PRIMARY_EVENT_IN[`SRC_ADC], group_active[1],
                     group_active[0], PRIMARY_EVENT_IN[`SRC_CP1],
                     4'h0};  // [R12]
    primary_ev[2] = {group_active[3], PRIMARY_EVENT_IN[`SRC_TB1],
                     PRIMARY_EVENT_IN[`SRC_TB0], group_active[2],
                     4'h0};  // [R12]
    primary_ev[3] = {group_active[5], group_active[4],
                     pin_edge[3], pin_edge[2], 4'h0};  // [R12]
  end

  // ****************************************************************
  // primary control registers
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      for (int i = 0; i < `NUM_PRIMARY_REGS; i++) begin
        primary_r[i] <= `REG_RESET;  // [R16]
      end
    end else begin
      for (int i = 0; i < `NUM_PRIMARY_REGS; i++) begin
        primary_r[i] <= next_reg(primary_r[i], primary_ev[i],
                          is_addr(SFR_ADDR_IN,
                                  8'(`SFR_PRIMARY_BASE + i)),
                          SFR_WDATA_IN,
                          (i == 0) ? `PRIMARY0_MASK
                                   : `PRIMARY_MASK);  // [R16] [R17]
      end
    end
  end

  // ****************************************************************
  // multi-function registers
  // ****************************************************************
  function automatic sfr_byte_t multi_mask(input int g);
    unique case (g)
      2:       multi_mask = `MULTI2_MASK;
      5:       multi_mask = `MULTI5_MASK;
      default: multi_mask = `MULTI_MASK;
    endcase
  endfunction

  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      for (int g = 0; g < `NUM_MULTI_REGS; g++) begin
        multi_r[g] <= `REG_RESET;  // [R16]
      end
    end else begin
      for (int g = 0; g < `NUM_MULTI_REGS; g++) begin
        multi_r[g] <= next_reg(multi_r[g], multi_ev[g],
                        is_addr(SFR_ADDR_IN,
                                8'(`SFR_MULTI_BASE + g)),
                        SFR_WDATA_IN, multi_mask(g));  // [R11] [R16]
      end
    end
  end

  // ****************************************************************
  // request to the core
  // ****************************************************************
  always_comb begin
    primary_pend = |(primary_r[0][6:4] & primary_r[0][3:1]);  // [R18]
    for (int i = 1; i < `NUM_PRIMARY_REGS; i++) begin
      primary_pend = primary_pend | pair_pending(primary_r[i]);  // [R18]
    end
  end

  assign IRQ_REQ_OUT = primary_r[0][`GLOBAL_EN_BIT]
                     & primary_pend;  // [R19]

  // idle wake only when the flag was not preset by software
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= IDLE_MODE_IN & supply_irq_fire
              & ~multi_r[`SUPPLY_GROUP][`SUPPLY_IRQ_FLAG];  // [R7] [R8]
    end
  end

  assign WAKE_OUT = wake_r;

  // ****************************************************************
  // read back
  // ****************************************************************
  always_comb begin
    rdata_nxt = 8'h00;
    if (SFR_ADDR_IN == `SFR_SUPPLY_MON) begin
      rdata_nxt = {2'b00, supply_low_flag,
                   supply_mon_r[`SM_ON_BIT:0]};  // [R2] [R10]
    end else if (SFR_ADDR_IN == `SFR_EDGE_SEL) begin
      rdata_nxt = edge_sel_r;
    end
    for (int i = 0; i < `NUM_PRIMARY_REGS; i++) begin
      if (SFR_ADDR_IN == 8'(`SFR_PRIMARY_BASE + i)) begin
        rdata_nxt = primary_r[i];
      end
    end
    for (int g = 0; g < `NUM_MULTI_REGS; g++) begin
      if (SFR_ADDR_IN == 8'(`SFR_MULTI_BASE + g)) begin
        rdata_nxt = multi_r[g];
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      SFR_RDATA_OUT <= 8'h00;
    end else begin
      SFR_RDATA_OUT <= rdata_nxt;
    end
  end

endmodule

`default_nettype wire

//--- interrupt_and_supply_monitor_ctrl_bench.sv
// self-checking bench of the interrupt and supply monitor controller
// assumes the checker and the supply model are compiled first
`timescale 1ns/10ps
`default_nettype none
module interrupt_and_supply_monitor_ctrl_bench;
  import irq_supply_pkg::*;
  logic        clk = 0, rst = 1, wr = 0, slp = 0, idl = 0;
  logic [7:0]  addr = 8'h00;
  sfr_byte_t   wd = 8'h00, rdat, v;
  logic        det, bg, irq, wake, below;
  trip_level_t lvl;
  logic [3:0]  pins = 4'h0;
  logic [4:0]  pev = 5'h00;
  logic [23:0] mev = 24'h000000;
  logic [12:0] vdd = 13'h1388;
  int          bad_count = 0, n_compared = 0, wakes = 0;

  always #4 clk = ~clk;
  always @(negedge clk) if (wake === 1'b1) wakes++;

  interrupt_and_supply_monitor_ctrl #(.RAISE_DELAY_CYCLES(4)) dut (
    .CLK_SYS_IN(clk), .RESET_IN(rst), .SFR_ADDR_IN(addr), .SFR_WR_IN(wr),
    .SFR_WDATA_IN(wd), .SFR_RDATA_OUT(rdat), .SLEEP_MODE_IN(slp),
    .IDLE_MODE_IN(idl), .SUPPLY_BELOW_TRIP_IN(below), .DETECTOR_ON_OUT(det),
    .TRIP_LEVEL_OUT(lvl), .BANDGAP_OUT_ENABLE_OUT(bg),
    .EXTERNAL_IRQ_PINS_IN(pins), .PRIMARY_EVENT_IN(pev),
    .MEMBER_EVENT_IN(mev), .IRQ_REQ_OUT(irq), .WAKE_OUT(wake));
  supply_source_model sup (.clk_in(clk), .detector_on_in(det),
    .trip_level_in(lvl), .vdd_mv_in(vdd), .below_trip_out(below));

  // ************************************************************
  // port tasks
  // ************************************************************
  task automatic chk(input string what, input sfr_byte_t exp, got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input sfr_byte_t d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output sfr_byte_t d);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1 d = rdat;
  endtask
  task automatic rc(input logic [7:0] a, input sfr_byte_t e, string what);
    sfr_byte_t d;
    rdr(a, d);
    chk(what, e, d);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    for (int a = 0; a < 12; a++) rc(8'(a), 8'h00, "reset");
    chk("outputs", 8'h00, {irq, wake, det, bg, 1'b0, lvl});
  endtask
  task automatic t_masks();
    sfr_byte_t m [12] = '{8'h1F, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF,
                          8'hFF, 8'hFF, 8'h33, 8'hFF, 8'hFF, 8'h77};
    for (int a = 0; a < 13; a++) wrr(8'(a), 8'hFF);
    for (int a = 0; a < 12; a++) rc(8'(a), m[a], "bits");
    rc(8'h0C, 8'h00, "unmapped");
    rc(8'hFF, 8'h00, "unmapped");
    chk("detector side", 8'h1F, {3'h0, det, bg, lvl});
    for (int a = 12; a >= 0; a--) wrr(8'(a), 8'h00);
    for (int a = 0; a < 12; a++) rc(8'(a), 8'h00, "cleared");
  endtask
  task automatic t_levels();
    @(posedge clk) vdd <= 13'h0C1C;
    for (int c = 0; c < 8; c++) begin
      wrr(8'h00, 8'h10 | 8'(c));
      wt(8);
      chk("trip level", 8'(c), {5'h00, lvl});
      rc(8'h00, 8'h10 | 8'(c) | (c > 4 ? 8'h20 : 8'h00), "low flag");
    end
    @(posedge clk) slp <= 1'b1;
    wt(8);
    chk("sleep", 8'h00, {7'h00, det});
    rc(8'h00, 8'h17, "flag in sleep");
    wrr(8'h00, 8'h00);
    @(posedge clk) slp <= 1'b0;
    @(posedge clk) vdd <= 13'h1388;
    wt(4);
    rc(8'h00, 8'h00, "detector off");
    wrr(8'h09, 8'h00);
  endtask
  task automatic t_lowirq();
    wrr(8'h09, 8'h01);
    wrr(8'h00, 8'h17);
    wt(8);
    @(posedge clk) idl <= 1'b1;
    @(posedge clk) vdd <= 13'h0BB8;
    v = 8'h00;
    for (int i = 0; i < 20 && v[5] !== 1'b1; i++) rdr(8'h00, v);
    rc(8'h09, 8'h01, "request held back");
    wt(12);
    rc(8'h09, 8'h11, "request raised");
    chk("wake", 8'h01, 8'(wakes));
    wrr(8'h04, 8'h08);
    wrr(8'h02, 8'h00);
    wt(2);
    chk("irq no global", 8'h00, {7'h00, irq});
    rc(8'h04, 8'h88, "group flag");
    wrr(8'h02, 8'h01);
    wt(2);
    chk("irq", 8'h01, {7'h00, irq});
    wrr(8'h04, 8'h00);
    wt(2);
    chk("irq masked", 8'h00, {7'h00, irq});
    @(posedge clk) vdd <= 13'h1388;
    wt(8);
    wrr(8'h09, 8'h11);
    @(posedge clk) vdd <= 13'h0BB8;
    wt(20);
    chk("no wake", 8'h01, 8'(wakes));
    @(posedge clk) idl <= 1'b0;
    for (int a = 0; a < 12; a++) wrr(8'(11 - a), 8'h00);
  endtask
  task automatic t_pins();
    logic [7:0] fa;
    for (int p = 0; p < 4; p++)
      for (int m = 0; m < 4; m++) begin
        fa = p < 2 ? 8'h02 : 8'h05;
        wrr(8'h01, 8'(m) << (2 * p));
        @(posedge clk) pins[p] <= 1'b1;
        wt(5);
        rc(fa, 8'(m & 1) << (4 + p % 2), "rise");
        wrr(fa, 8'h00);
        @(posedge clk) pins[p] <= 1'b0;
        wt(5);
        rc(fa, 8'(m >> 1) << (4 + p % 2), "fall");
        wrr(fa, 8'h00);
      end
  endtask
  task automatic t_sources();
    logic [7:0] pa [5] = '{8'h02, 8'h03, 8'h03, 8'h04, 8'h04};
    int         pb [5] = '{6, 4, 7, 5, 6};
    logic [7:0] ga [6] = '{8'h03, 8'h03, 8'h04, 8'h04, 8'h05, 8'h05};
    int         gb [6] = '{5, 6, 4, 7, 6, 7};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) pev <= 5'(1 << i);
      @(posedge clk) pev <= 5'h00;
      rc(pa[i], 8'(1 << pb[i]), "source flag");
      wrr(pa[i], 8'h00);
    end
    for (int g = 0; g < 6; g++) begin
      @(posedge clk) mev <= 24'(1 << (4 * g));
      @(posedge clk) mev <= 24'h000000;
      rc(8'(6 + g), 8'h10, "member flag");
      rc(ga[g], 8'h00, "group idle");
      wrr(8'(6 + g), 8'h11);
      wt(2);
      rc(ga[g], 8'(1 << gb[g]), "group flag");
      wrr(8'(6 + g), 8'h00);
      wrr(ga[g], 8'h00);
      rc(ga[g], 8'h00, "group cleared");
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    $display("reset test done");
    t_masks();
    $display("mask test done");
    t_levels();
    $display("level test done");
    t_lowirq();
    $display("supply irq test done");
    t_pins();
    $display("pin test done");
    t_sources();
    $display("source test done");
    tally_and_finish();
  end
  initial begin
    #200000;
    bad_count++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- irq_supply_cfg.svh
// constants of the interrupt and supply monitor controller
// assumes inclusion by bare name from the package and the controller module
`ifndef IRQ_SUPPLY_CFG_SVH
`define IRQ_SUPPLY_CFG_SVH

// register offsets on the special function register port
`define SFR_SUPPLY_MON     8'h00
`define SFR_EDGE_SEL       8'h01
`define SFR_PRIMARY_BASE   8'h02
`define SFR_MULTI_BASE     8'h06
`define NUM_PRIMARY_REGS   4
`define NUM_MULTI_REGS     6

// reset value of every register
`define REG_RESET          8'h00

// supply monitor register fields
`define SM_FLAG_BIT        5
`define SM_ON_BIT          4
`define SM_BANDGAP_BIT     3
`define SM_LEVEL_MSB       2
`define SM_WRITE_MASK      8'h1F

// primary control register fields, register 0 and the others
`define GLOBAL_EN_BIT      0
`define PRIMARY0_MASK      8'h7F
`define PRIMARY_MASK       8'hFF

// multi-function registers: implemented bits
`define MULTI_MASK         8'hFF
`define MULTI2_MASK        8'h33
`define MULTI5_MASK        8'h77

// supply-low request inside the multi-function registers
`define SUPPLY_GROUP       3
`define SUPPLY_IRQ_FLAG    4
`define SUPPLY_IRQ_EN      0

// primary source event positions on the event port
`define SRC_CP0            0
`define SRC_CP1            1
`define SRC_ADC            2
`define SRC_TB0            3
`define SRC_TB1            4
`define NUM_PRIMARY_SRC    5

// timing
`define CLK_SYS_MHZ        125
`define IRQ_RAISE_DELAY_NS 120000
`define IRQ_RAISE_DELAY_CYCLES \
  ((`IRQ_RAISE_DELAY_NS * `CLK_SYS_MHZ + 999) / 1000)

`endif

//--- irq_supply_checker.sv
// port-level checks of the interrupt and supply monitor controller
// assumes binding onto the controller's top module
`timescale 1ns/10ps
`default_nettype none
module irq_supply_checker (
  // clock and reset
  input wire logic                      CLK_SYS_IN,
  input wire logic                      RESET_IN,
  // register port and power mode
  input wire logic [7:0]                SFR_ADDR_IN,
  input wire logic                      SFR_WR_IN,
  input wire irq_supply_pkg::sfr_byte_t SFR_WDATA_IN,
  input wire irq_supply_pkg::sfr_byte_t SFR_RDATA_OUT,
  input wire logic                      SLEEP_MODE_IN,
  // detector and requests
  input wire logic                      DETECTOR_ON_OUT,
  input wire logic                      IRQ_REQ_OUT,
  input wire logic                      WAKE_OUT
);
  import irq_supply_pkg::*;
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RESET_IN);
  a_sleep_detector_off: assert property (
    SLEEP_MODE_IN |-> !DETECTOR_ON_OUT) else $error("detector on in sleep");
  a_detector_on_write: assert property (
    (SFR_WR_IN && SFR_ADDR_IN == 8'h00) |=> DETECTOR_ON_OUT ==
    ($past(SFR_WDATA_IN[4]) && !SLEEP_MODE_IN)) else $error("detector on");
  a_supply_top_zero: assert property (
    SFR_ADDR_IN == 8'h00 |=> SFR_RDATA_OUT[7:6] == 2'h0)
    else $error("supply top bits");
  a_primary_top_zero: assert property (
    SFR_ADDR_IN == 8'h02 |=> !SFR_RDATA_OUT[7]) else $error("primary bit 7");
  a_low_flag_gated: assert property (
    (SFR_ADDR_IN == 8'h00 && !DETECTOR_ON_OUT) |=> !SFR_RDATA_OUT[5])
    else $error("low flag while detector off");
  a_global_gates_irq: assert property (
    (SFR_WR_IN && SFR_ADDR_IN == 8'h02 && !SFR_WDATA_IN[0]) |=> !IRQ_REQ_OUT)
    else $error("request without global enable");
  a_wake_one_cycle: assert property (
    WAKE_OUT |=> !WAKE_OUT) else $error("wake longer than one cycle");
  a_edge_sel_readback: assert property (
    (SFR_WR_IN && SFR_ADDR_IN == 8'h01) ##1
    (!SFR_WR_IN && SFR_ADDR_IN == 8'h01) |=>
    SFR_RDATA_OUT == $past(SFR_WDATA_IN, 2)) else $error("edge select");
endmodule

bind interrupt_and_supply_monitor_ctrl irq_supply_checker chk (
  .CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN), .SFR_ADDR_IN(SFR_ADDR_IN),
  .SFR_WR_IN(SFR_WR_IN), .SFR_WDATA_IN(SFR_WDATA_IN),
  .SFR_RDATA_OUT(SFR_RDATA_OUT), .SLEEP_MODE_IN(SLEEP_MODE_IN),
  .DETECTOR_ON_OUT(DETECTOR_ON_OUT), .IRQ_REQ_OUT(IRQ_REQ_OUT),
  .WAKE_OUT(WAKE_OUT));
`default_nettype wire

//--- irq_supply_pkg.sv
// types of the interrupt and supply monitor controller
// assumes irq_supply_cfg.svh is on the include path
`default_nettype none
`include "irq_supply_cfg.svh"

package irq_supply_pkg;

  typedef logic [7:0] sfr_byte_t;
  typedef logic [2:0] trip_level_t;

  typedef enum logic [1:0] {
    EDGE_OFF  = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_t;

  typedef enum logic [1:0] {
    DLY_WAIT  = 2'b00,
    DLY_COUNT = 2'b01,
    DLY_DONE  = 2'b11
  } delay_state_t;

endpackage

`default_nettype wire

//--- pin_edge_detect.sv
// edge detection for the external interrupt pins
// assumes asynchronous pins; each passes two flip-flops first
`timescale 1ns/10ps
`default_nettype none

module pin_edge_detect #(
  parameter int unsigned NUM_PINS = 4
) (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // pins and edge selects
  input  wire logic [NUM_PINS-1:0]   pins_in,
  input  wire logic [2*NUM_PINS-1:0] sel_in,
  // one-cycle detected edges
  output logic      [NUM_PINS-1:0]   edge_out
);
  import irq_supply_pkg::*;

  logic [NUM_PINS-1:0] meta_r;
  logic [NUM_PINS-1:0] sync_r;
  logic [NUM_PINS-1:0] prev_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pins_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      unique case (edge_sel_t'(sel_in[2*i +: 2]))
        EDGE_OFF:  edge_out[i] = 1'b0;
        EDGE_RISE: edge_out[i] = sync_r[i] & ~prev_r[i];
        EDGE_FALL: edge_out[i] = ~sync_r[i] & prev_r[i];
        EDGE_BOTH: edge_out[i] = sync_r[i] ^ prev_r[i];
      endcase  // [R14]
    end
  end

endmodule

`default_nettype wire

//--- supply_irq_delay.sv
// fixed delay between supply-low flag rise and its request
// assumes level_in is already synchronous to clk_in
`timescale 1ns/10ps
`default_nettype none

module supply_irq_delay #(
  parameter int unsigned CYCLES = 15000
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // flag level and delayed request pulse
  input  wire logic level_in,
  output logic      fire_out
);
  import irq_supply_pkg::*;

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);

  generate
    if (CYCLES < 1) begin : g_bad
      $error("supply_irq_delay: CYCLES must be at least 1");
    end
  endgenerate

  delay_state_t     state_r;
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r  <= DLY_WAIT;
      cnt_r    <= '0;
      fire_out <= 1'b0;
    end else begin
      fire_out <= 1'b0;
      unique case (state_r)
        DLY_WAIT: begin
          cnt_r <= CNT_W'(1);
          if (level_in) begin
            state_r <= DLY_COUNT;
          end
        end
        DLY_COUNT: begin
          if (!level_in) begin
            state_r <= DLY_WAIT;
          end else if (cnt_r == CNT_W'(CYCLES)) begin
            fire_out <= 1'b1;  // [R6]
            state_r  <= DLY_DONE;
          end else begin
            cnt_r <= cnt_r + CNT_W'(1);
          end
        end
        DLY_DONE: begin
          if (!level_in) begin
            state_r <= DLY_WAIT;
          end
        end
        default: state_r <= DLY_WAIT;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- supply_source_model.sv
// behavioural supply comparator facing the detector outputs
// assumes a free-running system clock
`timescale 1ns/10ps
`default_nettype none
module supply_source_model (
  // clock and detector control
  input  wire logic                        clk_in,
  input  wire logic                        detector_on_in,
  input  wire irq_supply_pkg::trip_level_t trip_level_in,
  // supply in millivolts and comparator output
  input  wire logic [12:0]                 vdd_mv_in,
  output logic                             below_trip_out
);
  import irq_supply_pkg::*;
  // trip points in millivolts, lowest code first
  localparam logic [12:0] TRIP_MV [8] = '{13'h07D0, 13'h0898, 13'h0960,
    13'h0A8C, 13'h0BB8, 13'h0CE4, 13'h0E10, 13'h0FA0};
  initial below_trip_out = 1'b0;
  // unpowered comparator output wanders instead of holding
  always @(posedge clk_in)
    if (detector_on_in)
      below_trip_out <= vdd_mv_in < TRIP_MV[trip_level_in];
    else
      below_trip_out <= !below_trip_out;
endmodule
`default_nettype wire
